// ---- cmm_pkg.sv ----
`default_nettype none
package cmm_pkg;
  // ==========================================================
  // Word layout
  localparam int NCH = 2;
  localparam int WBITS = 16;
  localparam int CTL_BIT = 15;
  localparam int RB_BIT = 14;
  localparam int DADR_HI = 13;
  localparam int DADR_LO = 11;
  localparam int RADR_HI = 10;
  localparam int RADR_LO = 8;
  localparam int DATA_HI = 7;
  // ==========================================================
  // Configuration register fields
  localparam int CFG_MM = 0;
  localparam int CFG_LB = 2;
  localparam int CNT_HI = 5;
  localparam int CNT_LO = 3;
  localparam logic [2:0] CFG_REG = 3'h0;
  localparam logic [2:0] DADR_SELF = 3'h0;
  // ==========================================================
  // Counts and reset values
  localparam logic [3:0] LAST_BIT = 4'hf;
  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // ==========================================================
  // Types
  typedef logic [15:0] cmm_word_type;
  typedef struct packed {
    cmm_word_type ch2;
    cmm_word_type ch1;
  } cmm_pair_type;
  typedef enum logic [1:0] {SL_IDLE, SL_SHIFT, SL_END, SL_LOAD} cmm_slot_type;
  // ==========================================================
  // Helpers
  function automatic logic [2:0] cmm_dec_addr(input logic [2:0] a);
    return a - CNT_ONE;
  endfunction
  function automatic logic cmm_is_ctl(input cmm_word_type w, input logic mm,
                                      input logic force_ctl);
    return force_ctl | ~mm | w[CTL_BIT];
  endfunction
endpackage
`default_nettype wire

// ---- cmm_regmem.sv ----
`timescale 1ns/100ps
`default_nettype none
module cmm_regmem
  import cmm_pkg::*;
(
  input wire logic clk, // Link clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic we, // Write strobe
  input wire logic [2:0] waddr, // Write address
  input wire logic [7:0] wdata, // Write data
  input wire logic [2:0] raddr, // Read address
  output logic [7:0] rdata_r // Registered read data
);
  // ==========================================================
  // Storage
  logic [7:0] mem_r [8];

  // Write port, cleared at reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        mem_r[i] <= REG_RST;
      end
    end else if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  // Read port, one cycle latency
  always_ff @(posedge clk) begin
    rdata_r <= mem_r[raddr];
  end
endmodule
`default_nettype wire

// ---- cmm_cascade_port.sv ----
`timescale 1ns/100ps
`default_nettype none
module cmm_cascade_port
  import cmm_pkg::*;
(
  input wire logic SYS_CLK, // System clock
  input wire logic RSTN, // Synchronous reset, active low
  input wire logic LINK_CLK, // Serial link clock
  input wire logic INBOUND_FRAME_SYNC, // Frame sync from host
  input wire logic SERIAL_IN, // Serial data from host
  output logic OUTBOUND_FRAME_SYNC, // Frame sync toward host
  output logic SERIAL_OUT, // Serial data toward host
  input wire logic ADC_STB, // New converter results
  input wire cmm_pair_type ADC_WORDS, // Converter results
  output logic [1:0] DAC_STB, // DAC update pulse per channel
  output cmm_pair_type DAC_WORDS // DAC words per channel
);
  // ==========================================================
  // System side: converter capture
  cmm_pair_type adc_hold_r;
  logic adc_tgl_r;

  // Hold results, announce by toggle
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      adc_hold_r <= '0;
      adc_tgl_r <= 1'h0;
    end else if (ADC_STB) begin
      adc_hold_r <= ADC_WORDS;
      adc_tgl_r <= ~adc_tgl_r;
    end
  end

  // ==========================================================
  // Link side: reset and pin synchronisers
  logic [1:0] lrst_sy_r;
  logic lrst_n;
  logic [1:0] ifs_sy_r;
  logic [1:0] din_sy_r;
  logic [2:0] adc_sy_r;

  // Reset release into link domain
  always_ff @(posedge LINK_CLK) begin
    lrst_sy_r <= {lrst_sy_r[0], RSTN};
  end
  assign lrst_n = lrst_sy_r[1];

  // Two flops on every pin, edge history on the toggle
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      ifs_sy_r <= '0;
      din_sy_r <= '0;
      adc_sy_r <= '0;
    end else begin
      ifs_sy_r <= {ifs_sy_r[0], INBOUND_FRAME_SYNC};
      din_sy_r <= {din_sy_r[0], SERIAL_IN};
      adc_sy_r <= {adc_sy_r[1:0], adc_tgl_r};
    end
  end

  // ==========================================================
  // Link side: state
  cmm_slot_type st_r;
  logic [3:0] bit_r;
  cmm_word_type sh_r [NCH];
  logic [NCH-1:0] pend_r, hold_r, adc_r, act_r, snd_r, rb_r, after_r;
  logic [NCH-1:0] mm_r, lb_r, dac_tgl_r;
  logic [2:0] devcnt_r [NCH];
  logic [2:0] cnt_r [NCH];
  cmm_word_type dac_word_r [NCH];
  logic pass1_r, adc_req_r, out_fs_r, dout_r;
  logic [7:0] rdata [NCH];
  logic [NCH-1:0] fs_in, fs_out, ctl, mine, fwd, we, cnt_ev, ser_in;
  cmm_word_type adc_word [NCH];
  logic start, adc_load;

  // Frame sync chaining and word classification
  always_comb begin
    fs_in[0] = ifs_sy_r[1];
    fs_out[0] = pend_r[0] | (fs_in[0] & hold_r[0]);
    fs_in[1] = fs_out[0];
    fs_out[1] = pend_r[1] | (fs_in[1] & hold_r[1]);
    start = (st_r == SL_IDLE) && (fs_in[0] || (pend_r != '0));
    adc_load = (st_r == SL_IDLE) && !start && adc_req_r;
    ser_in[0] = din_sy_r[1];
    ser_in[1] = sh_r[0][CTL_BIT];
    adc_word[0] = adc_hold_r.ch1;
    adc_word[1] = adc_hold_r.ch2;
    fwd[0] = 1'h0;
    fwd[1] = pass1_r;
    for (int k = 0; k < NCH; k++) begin
      ctl[k] = cmm_is_ctl(sh_r[k], mm_r[k], after_r[k]) & ~fwd[k];
      mine[k] = sh_r[k][DADR_HI:DADR_LO] == DADR_SELF;
      we[k] = (st_r == SL_END) && act_r[k] && ctl[k] && mine[k]
              && !sh_r[k][RB_BIT];
      cnt_ev[k] = (st_r == SL_END) && act_r[0] && !ctl[0] && mm_r[k];
    end
  end

  // Slot sequencing: sync, 16 bits, decode, load
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      st_r <= SL_IDLE;
      bit_r <= '0;
    end else begin
      case (st_r)
        SL_IDLE: begin
          bit_r <= '0;
          if (start) begin
            st_r <= SL_SHIFT;
          end
        end
        SL_SHIFT: begin
          bit_r <= bit_r + 4'h1;
          if (bit_r == LAST_BIT) begin
            st_r <= SL_END;
          end
        end
        SL_END: st_r <= SL_LOAD;
        default: st_r <= SL_IDLE;
      endcase
    end
  end

  // Slot roles latched at start
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      act_r <= '0;
      snd_r <= '0;
      pass1_r <= 1'h0;
    end else if (start) begin
      act_r <= fs_in;
      snd_r <= fs_out;
      pass1_r <= fs_out[0] & adc_r[0];
    end
  end

  // Serial pins toward host
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      out_fs_r <= 1'h0;
      dout_r <= 1'h0;
    end else begin
      out_fs_r <= start & fs_out[1];
      dout_r <= (st_r == SL_SHIFT) ? sh_r[1][CTL_BIT] : 1'h0;
    end
  end
  assign OUTBOUND_FRAME_SYNC = out_fs_r;
  assign SERIAL_OUT = dout_r;

  // Shift registers: shift, decrement, readback, converter load
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      sh_r <= '{default: WORD_RST};
    end else begin
      for (int k = 0; k < NCH; k++) begin
        if (st_r == SL_SHIFT && (act_r[k] || snd_r[k])) begin
          sh_r[k] <= {sh_r[k][WBITS-2:0], ser_in[k]};
        end else if (st_r == SL_END && act_r[k] && ctl[k] && !mine[k]) begin
          sh_r[k][DADR_HI:DADR_LO] <= cmm_dec_addr(sh_r[k][DADR_HI:DADR_LO]);
        end else if (st_r == SL_LOAD && rb_r[k]) begin
          sh_r[k] <= {1'h1, 1'h1, cmm_dec_addr(DADR_SELF),
                      sh_r[k][RADR_HI:RADR_LO], rdata[k]};
        end else if (adc_load) begin
          sh_r[k] <= adc_word[k];
        end
      end
    end
  end

  // Word ownership flags
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      pend_r <= '0;
      hold_r <= '0;
      adc_r <= '0;
      rb_r <= '0;
    end else begin
      for (int k = 0; k < NCH; k++) begin
        case (st_r)
          SL_END: begin
            if (snd_r[k]) begin
              pend_r[k] <= 1'h0;
              hold_r[k] <= 1'h0;
              adc_r[k] <= 1'h0;
            end
            if (act_r[k]) begin
              hold_r[k] <= !ctl[k] && !fwd[k];
              pend_r[k] <= fwd[k] || (ctl[k] && !mine[k]);
              adc_r[k] <= fwd[k];
              rb_r[k] <= ctl[k] && mine[k] && sh_r[k][RB_BIT];
            end
          end
          SL_LOAD: begin
            if (rb_r[k]) begin
              pend_r[k] <= 1'h1;
              rb_r[k] <= 1'h0;
            end
          end
          default: begin
            if (adc_load) begin
              pend_r[k] <= 1'h1;
              hold_r[k] <= 1'h0;
              adc_r[k] <= 1'h1;
            end
          end
        endcase
      end
    end
  end

  // Configuration shadow and post-write control window
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      mm_r <= '0;
      lb_r <= '0;
      after_r <= '0;
      devcnt_r <= '{default: 3'h0};
    end else begin
      for (int k = 0; k < NCH; k++) begin
        if (we[k] && sh_r[k][RADR_HI:RADR_LO] == CFG_REG) begin
          mm_r[k] <= sh_r[k][CFG_MM];
          lb_r[k] <= sh_r[k][CFG_LB];
          devcnt_r[k] <= sh_r[k][CNT_HI:CNT_LO];
        end
        if (we[k] && lb_r[k]) begin
          after_r[k] <= 1'h1;
        end else if (adc_load) begin
          after_r[k] <= 1'h0;
        end
      end
    end
  end

  // Frame counters and DAC update
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      cnt_r <= '{default: 3'h0};
      dac_tgl_r <= '0;
      dac_word_r <= '{default: WORD_RST};
    end else begin
      for (int k = 0; k < NCH; k++) begin
        if (cnt_ev[k]) begin
          if (cnt_r[k] + CNT_ONE == devcnt_r[k] || devcnt_r[k] == 3'h0) begin
            cnt_r[k] <= 3'h0;
            dac_tgl_r[k] <= ~dac_tgl_r[k];
            dac_word_r[k] <= sh_r[k];
          end else begin
            cnt_r[k] <= cnt_r[k] + CNT_ONE;
          end
        end
      end
    end
  end

  // Converter request, set wins over clear
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      adc_req_r <= 1'h0;
    end else begin
      adc_req_r <= (adc_sy_r[2] ^ adc_sy_r[1]) | (adc_req_r & ~adc_load);
    end
  end

  // Register memories, one per channel
  for (genvar g = 0; g < NCH; g++) begin : g_mem
    cmm_regmem u_mem (
      .clk(LINK_CLK),
      .rst_n(lrst_n),
      .we(we[g]),
      .waddr(sh_r[g][RADR_HI:RADR_LO]),
      .wdata(sh_r[g][DATA_HI:0]),
      .raddr(sh_r[g][RADR_HI:RADR_LO]),
      .rdata_r(rdata[g])
    );
  end

  // ==========================================================
  // System side: DAC update crossing
  logic [1:0] dac_sy0_r, dac_sy1_r, dac_sy2_r;

  // Toggle synchroniser with edge history
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      dac_sy0_r <= '0;
      dac_sy1_r <= '0;
      dac_sy2_r <= '0;
    end else begin
      dac_sy0_r <= dac_tgl_r;
      dac_sy1_r <= dac_sy0_r;
      dac_sy2_r <= dac_sy1_r;
    end
  end

  // Strobe and word outputs
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      DAC_STB <= '0;
      DAC_WORDS <= '0;
    end else begin
      DAC_STB <= dac_sy1_r ^ dac_sy2_r;
      if (dac_sy1_r[0] ^ dac_sy2_r[0]) begin
        DAC_WORDS.ch1 <= dac_word_r[0];
      end
      if (dac_sy1_r[1] ^ dac_sy2_r[1]) begin
        DAC_WORDS.ch2 <= dac_word_r[1];
      end
    end
  end

  // ==========================================================
  // Checks
  sequence s_slot_tail;
    st_r == SL_END ##1 st_r == SL_LOAD ##1 st_r == SL_IDLE;
  endsequence
  sequence s_rb_out;
    pend_r[1] && sh_r[1][DADR_HI:DADR_LO] == 3'h7 ##[1:2] OUTBOUND_FRAME_SYNC;
  endsequence

  AST_SLOT_TAIL: assert property (
    @(posedge LINK_CLK) disable iff (!lrst_n)
    (st_r == SL_SHIFT && bit_r == LAST_BIT) |=> s_slot_tail)
    else $error("slot tail out of order");
  AST_RB_OUT: assert property (
    @(posedge LINK_CLK) disable iff (!lrst_n)
    (st_r == SL_LOAD && rb_r[1]) |=> s_rb_out)
    else $error("readback not sent with address 7");
  AST_RB_NO_WRITE: assert property (
    @(posedge LINK_CLK) disable iff (!lrst_n)
    (st_r == SL_END && act_r[0] && ctl[0] && sh_r[0][RB_BIT]) |-> !we[0])
    else $error("readback request wrote register");
  AST_FWD_DEC: assert property (
    @(posedge LINK_CLK) disable iff (!lrst_n)
    (st_r == SL_END && act_r[1] && ctl[1] && !mine[1]) |=>
    pend_r[1] && sh_r[1][DADR_HI:DADR_LO] == cmm_dec_addr($past(sh_r[1][DADR_HI:DADR_LO])))
    else $error("forwarded word not decremented");
  AST_CTL_NO_COUNT: assert property (
    @(posedge LINK_CLK) disable iff (!lrst_n)
    (st_r == SL_END && act_r[0] && ctl[0]) |=> $stable(cnt_r[0]) && $stable(dac_tgl_r[0]))
    else $error("control word advanced counter");
  AST_DAC_HIT: assert property (
    @(posedge LINK_CLK) disable iff (!lrst_n)
    $changed(dac_tgl_r[0]) |-> cnt_r[0] == 3'h0 && $past(cnt_ev[0]))
    else $error("DAC update without count match");
  AST_ORDER: assert property (
    @(posedge LINK_CLK) disable iff (!lrst_n)
    (start && pend_r[1]) |=> OUTBOUND_FRAME_SYNC ##1 !OUTBOUND_FRAME_SYNC)
    else $error("second channel word not sent first");
  AST_MSB_DATA: assert property (
    @(posedge LINK_CLK) disable iff (!lrst_n)
    (st_r == SL_END && act_r[0] && mm_r[0] && !after_r[0] && !sh_r[0][CTL_BIT])
    |=> hold_r[0] && !pend_r[0])
    else $error("data word not held");
  AST_LB_CTL: assert property (
    @(posedge LINK_CLK) disable iff (!lrst_n)
    (st_r == SL_END && act_r[0] && after_r[0] && !mine[0]) |=> pend_r[0])
    else $error("word after write not forwarded as control");
  AST_DAC_STB: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    DAC_STB[0] |=> !DAC_STB[0])
    else $error("DAC strobe longer than one cycle");
endmodule
`default_nettype wire

// ---- cmm_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Host serial port model
module cmm_host_model (
  input wire logic link_clk, // Link clock
  output logic fs_out, // Frame sync to port
  output logic sd_out, // Serial data to port
  input wire logic fs_in, // Frame sync from port
  input wire logic sd_in // Serial data from port
);
  logic busy;
  logic [15:0] w;
  logic [15:0] rx_q[$];
  // Quiet start
  initial begin
    fs_out = 1'b0;
    sd_out = 1'b0;
    busy = 1'b0;
    w = 16'h0000;
  end
  // Idle data line toggles so no stale bit looks valid
  always @(negedge link_clk) begin
    if (!busy) begin
      sd_out <= ~sd_out;
    end
  end
  // Sync pulse, 16 bits MSB first, then a gap for forwarding
  task automatic send(input logic [15:0] d);
    busy = 1'b1;
    @(negedge link_clk);
    fs_out <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
      @(negedge link_clk);
      fs_out <= 1'b0;
      sd_out <= d[i];
    end
    @(negedge link_clk);
    busy = 1'b0;
    repeat (40) @(negedge link_clk);
  endtask
  // Capture one word after each outbound sync, sampled mid-bit
  initial begin
    forever begin
      @(negedge link_clk);
      if (fs_in === 1'b1) begin
        repeat (16) begin
          @(negedge link_clk);
          w = {w[14:0], sd_in};
        end
        rx_q.push_back(w);
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Bench for the cascade port
module tb_top
  import cmm_pkg::*;
;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rstn = 1'b0;
  logic adc_stb = 1'b0;
  cmm_pair_type adc_words = '0;
  logic ifs, isd, ofs, osd;
  logic [1:0] dac_stb;
  cmm_pair_type dac_words;
  int error_cnt = 0;
  int compares = 0;
  logic [31:0] seed = 32'hfc513146;
  logic [15:0] exp_q[$];
  logic [15:0] dac_seen[2];
  int dac_n[2] = '{0, 0};
  logic [15:0] w1, w2;
  logic [7:0] cfg = 8'h11;
  // Clocks, link clock offset in phase
  always #20 sys_clk = ~sys_clk;
  initial begin
    #7.3;
    forever #62.5 link_clk = ~link_clk;
  end
  cmm_cascade_port dut (
    .SYS_CLK(sys_clk),
    .RSTN(rstn),
    .LINK_CLK(link_clk),
    .INBOUND_FRAME_SYNC(ifs),
    .SERIAL_IN(isd),
    .OUTBOUND_FRAME_SYNC(ofs),
    .SERIAL_OUT(osd),
    .ADC_STB(adc_stb),
    .ADC_WORDS(adc_words),
    .DAC_STB(dac_stb),
    .DAC_WORDS(dac_words)
  );
  cmm_host_model host (
    .link_clk(link_clk),
    .fs_out(ifs),
    .sd_out(isd),
    .fs_in(ofs),
    .sd_in(osd)
  );
  // DAC strobe monitor, sampled away from the launching edge
  always @(negedge sys_clk) begin
    for (int k = 0; k < 2; k++) begin
      if (dac_stb[k] === 1'b1) begin
        dac_n[k] <= dac_n[k] + 1;
        dac_seen[k] <= (k == 1) ? dac_words.ch2 : dac_words.ch1;
      end
    end
  end
  // Xorshift source, MSB cleared to mark data words
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0] & 16'h7fff;
  endfunction
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Wait bounded for the expected words, then compare in order
  task automatic expect_rx();
    int n;
    n = 0;
    while (host.rx_q.size() < exp_q.size() && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    check(16'(host.rx_q.size()), 16'(exp_q.size()));
    while (exp_q.size() > 0 && host.rx_q.size() > 0) begin
      check(host.rx_q.pop_front(), exp_q.pop_front());
    end
  endtask
  // Verdict
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #400000;
    error_cnt++;
    final_report();
  end
  // Main sequence
  initial begin
    repeat (14) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (20) @(negedge sys_clk);
    // Mixed mode, count 2, ch2 word first; both consumed
    host.send({2'h2, 3'h1, CFG_REG, cfg});
    host.send({2'h2, 3'h0, CFG_REG, cfg});
    expect_rx();
    $display("config test done");
    // Converter event: ch2 word reaches host before ch1 word
    @(negedge sys_clk);
    adc_words.ch1 = rnd();
    adc_words.ch2 = rnd();
    adc_stb = 1'b1;
    @(negedge sys_clk);
    adc_stb = 1'b0;
    exp_q.push_back(adc_words.ch2);
    exp_q.push_back(adc_words.ch1);
    expect_rx();
    $display("adc test done");
    // Readback of config from both channels
    host.send({2'h3, 3'h1, CFG_REG, 8'h00});
    host.send({2'h3, 3'h0, CFG_REG, 8'h00});
    exp_q.push_back({2'h3, 3'h7, CFG_REG, cfg});
    exp_q.push_back({2'h3, 3'h6, CFG_REG, cfg});
    expect_rx();
    $display("readback test done");
    // DAC-only period; control frames above must not count
    w2 = rnd();
    w1 = rnd();
    host.send(w2);
    check(16'(dac_n[0] + dac_n[1]), 16'h0000);
    host.send(w1);
    check(16'(dac_n[0]), 16'h0001);
    check(16'(dac_n[1]), 16'h0001);
    check(dac_seen[0], w1);
    check(dac_seen[1], w2);
    $display("dac test done");
    // Loopback on: held DAC words flush out, ch2 word first
    cfg = 8'h15;
    host.send({2'h2, 3'h1, CFG_REG, cfg});
    host.send({2'h2, 3'h0, CFG_REG, cfg});
    exp_q.push_back(w2);
    exp_q.push_back(w1);
    expect_rx();
    // Write again, then data words come back as decremented control
    host.send({2'h2, 3'h1, CFG_REG, cfg});
    host.send({2'h2, 3'h0, CFG_REG, cfg});
    w1 = rnd();
    w1[13:11] = 3'h2;
    w2 = rnd();
    w2[13:11] = 3'h3;
    host.send(w1);
    host.send(w2);
    exp_q.push_back({w1[15:14], 3'h0, w1[10:0]});
    exp_q.push_back({w2[15:14], 3'h1, w2[10:0]});
    expect_rx();
    check(16'(dac_n[0] + dac_n[1]), 16'h0002);
    $display("loopback test done");
    final_report();
  end
endmodule
`default_nettype wire
